// >>> include/stfr_regs.svh
// Command code, field positions, reset value and timing constants of the startup-timeout block.
`ifndef STFR_REGS_SVH
`define STFR_REGS_SVH
`define STFR_CMD_ACTION 8'h63
`define STFR_RESP_MSB 7
`define STFR_RESP_LSB 6
`define STFR_RETRY_MSB 5
`define STFR_RETRY_LSB 3
`define STFR_DELAY_MSB 2
`define STFR_DELAY_LSB 0
`define STFR_ACTION_RST 8'hC0
`define STFR_RETRY_NONE 3'h0
`define STFR_RETRY_FOREVER 3'h7
`define STFR_MS_NS 1000000
`define STFR_CLK_NS 40
`endif

// >>> include/stfr_pkg.sv
// Types shared by the startup-timeout fault-response modules.
package stfr_pkg;
    typedef enum logic [1:0] {
        STFR_RESP_IGNORE = 2'b00,
        STFR_RESP_OPERATE = 2'b01,
        STFR_RESP_DISABLE = 2'b10,
        STFR_RESP_LATCH = 2'b11
    } stfr_resp_e;
    typedef enum logic [2:0] {
        STFR_ST_OFF = 3'b000,
        STFR_ST_RAMP = 3'b001,
        STFR_ST_RUN = 3'b010,
        STFR_ST_OPERATE = 3'b011,
        STFR_ST_WAIT = 3'b100,
        STFR_ST_LATCHED = 3'b101
    } stfr_state_e;
endpackage

// >>> include/stfr_tmr_if.sv
// Carrier between the sequencer and its millisecond timer.
`timescale 1ns/100ps
interface stfr_tmr_if;
    logic clear;
    logic [15:0] elapsed_ms;
    modport ctrl (output clear, input elapsed_ms);
    modport tmr (input clear, output elapsed_ms);
endinterface

// >>> design/stfr_timer.sv
// Millisecond divider and saturating elapsed-time counter.
`timescale 1ns/100ps
module stfr_timer #(
    parameter int MS_CYCLES = 25000
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Timer carrier
    stfr_tmr_if.tmr tmr
);
    import stfr_pkg::*;

    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic [15:0] elapsed;
    logic [15:0] next_elapsed;
    logic ms_tick;

    initial begin
        if (MS_CYCLES < 1 || MS_CYCLES > 65536) begin
            $error("MS_CYCLES out of range");
        end
    end

    // ----------------------------------------------------------------
    // One-cycle enable each millisecond, restarted with the count.
    // ----------------------------------------------------------------
    assign ms_tick = (div_cnt == 16'(MS_CYCLES - 1));

    always_comb begin
        next_div_cnt = div_cnt + 16'h0001;
        next_elapsed = elapsed;
        if (tmr.clear) begin
            next_div_cnt = 16'h0000;
            next_elapsed = 16'h0000;
        end else if (ms_tick) begin
            next_div_cnt = 16'h0000;
            // Saturation keeps a long ramp from wrapping past the limit.
            if (elapsed != 16'hFFFF) begin
                next_elapsed = elapsed + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            div_cnt <= 16'h0000;
            elapsed <= 16'h0000;
        end else begin
            div_cnt <= next_div_cnt;
            elapsed <= next_elapsed;
        end
    end

    assign tmr.elapsed_ms = elapsed;
endmodule

// >>> design/stfr_top.sv
// Startup-timeout fault detection and response sequencer with its action setting.
//
// Contract
// RL1: Action setting is one byte at command 0x63, byte read and write.
// RL2: Bits 7:6 response, 5:3 retries, 2:0 delay multiplier; some responses unsupported.
// RL3: Response 00 keeps regulating without interruption after the fault.
// RL4: Response 01 operates for the delay, then follows retries if fault remains.
// RL5: Response 10 disables output at once, then follows retries.
// RL6: Response 11 stays off until clear, clear-faults, reset, off-on or bias loss; the code also leaves latch-off on another shutdown fault.
// RL7: Retry setting 000 never restarts; output stays off until cleared.
// RL8: Retry settings 1 to 6 restart that often, then latch off.
// RL9: Restart spacing equals multiplier times the fault's delay time unit.
// RL10: Retry setting 111 retries forever until off command, bias loss, other fault.
// RL11: Multiplier is two to the field value, shared by delay and spacing.
// RL12: Delay time unit comes from a separate configuration register.
// RL13: This fault uses the output-voltage fault delay time unit.
// RL14: Fault when output misses undervoltage threshold within limit milliseconds.
// RL15: A limit of zero disables the startup-timeout check.
// RL16: Attempt counter clears on fault clear or off-then-on; the code clears it on a fault clear only in the latched-off state.
// RL17: Unsupported responses are mapped; read back returns the value in effect.
`timescale 1ns/100ps
`include "stfr_regs.svh"
module stfr_top #(
    parameter int MS_CYCLES = `STFR_MS_NS / `STFR_CLK_NS,
    parameter logic [3:0] RESP_SUPPORT = 4'hF
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Command port
    input wire logic [7:0] i_cmd_code,
    input wire logic i_wr_stb,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd_stb,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    // Fault clearing and output command
    input wire logic i_clear_status_bit,
    input wire logic i_clear_faults,
    input wire logic i_output_cmd_on,
    input wire logic i_other_fault_off,
    // Converter sensing and configuration
    input wire logic i_vout_above_uv,
    input wire logic [15:0] i_ton_max_limit_ms,
    input wire logic [7:0] i_vout_fault_unit_ms,
    // Converter control and status
    output logic o_output_enable,
    output logic o_ton_max_fault,
    output logic o_latched_off,
    output logic [2:0] o_attempts,
    output stfr_pkg::stfr_state_e o_state
);
    import stfr_pkg::*;

    initial begin
        if (!RESP_SUPPORT[3]) begin
            $error("latch-off response must be supported");
        end
    end

    stfr_tmr_if tmr_bus ();

    stfr_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .tmr(tmr_bus.ctrl)
    );

    // ----------------------------------------------------------------
    // Helpers.
    // ----------------------------------------------------------------
    // Unsupported responses fall back to latch-off, the safest behaviour.
    function automatic logic [7:0] map_action(input logic [7:0] raw);
        logic [7:0] res;
        res = raw;
        if (!RESP_SUPPORT[raw[`STFR_RESP_MSB:`STFR_RESP_LSB]]) begin
            res[`STFR_RESP_MSB:`STFR_RESP_LSB] = STFR_RESP_LATCH;
        end
        return res;
    endfunction

    function automatic logic [15:0] delay_ms(input logic [7:0] unit, input logic [2:0] expo);
        return 16'({8'h00, unit} << expo);
    endfunction

    // ----------------------------------------------------------------
    // Action setting register.
    // ----------------------------------------------------------------
    logic [7:0] action;
    logic [7:0] next_action;
    logic [7:0] next_rd_data;
    logic next_rd_valid;
    logic hit;

    assign hit = (i_cmd_code == `STFR_CMD_ACTION);

    always_comb begin
        next_action = action;
        next_rd_data = o_rd_data;
        next_rd_valid = 1'b0;
        if (i_wr_stb && hit) begin
            next_action = map_action(i_wr_data); // RL1 RL17
        end
        if (i_rd_stb && hit) begin
            next_rd_data = action; // RL1 RL17
            next_rd_valid = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            action <= `STFR_ACTION_RST;
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            action <= next_action;
            o_rd_data <= next_rd_data;
            o_rd_valid <= next_rd_valid;
        end
    end

    // ----------------------------------------------------------------
    // Fault response sequencer.
    // ----------------------------------------------------------------
    stfr_resp_e resp;
    logic [2:0] retries;
    logic [2:0] expo;
    logic [15:0] delay_lim;
    logic fault_evt;
    logic delay_done;
    logic can_retry;
    logic clear_req;
    stfr_state_e state;
    stfr_state_e next_state;
    logic [2:0] attempts;
    logic [2:0] next_attempts;
    logic next_fault;

    assign resp = stfr_resp_e'(action[`STFR_RESP_MSB:`STFR_RESP_LSB]); // RL2
    assign retries = action[`STFR_RETRY_MSB:`STFR_RETRY_LSB];
    assign expo = action[`STFR_DELAY_MSB:`STFR_DELAY_LSB];
    assign delay_lim = delay_ms(i_vout_fault_unit_ms, expo); // RL11 RL12 RL13
    assign delay_done = (tmr_bus.elapsed_ms >= delay_lim);
    assign clear_req = i_clear_status_bit || i_clear_faults;
    // A zero limit disables the check entirely.
    assign fault_evt = (state == STFR_ST_RAMP) && !i_vout_above_uv
        && (i_ton_max_limit_ms != 16'h0000) && i_output_cmd_on && !i_other_fault_off
        && (tmr_bus.elapsed_ms >= i_ton_max_limit_ms); // RL14 RL15
    assign can_retry = (retries == `STFR_RETRY_FOREVER)
        || ((retries != `STFR_RETRY_NONE) && (attempts < retries)); // RL7 RL8 RL10

    always_comb begin
        next_state = state;
        next_attempts = attempts;
        // Set wins over a clear in the same cycle.
        next_fault = fault_evt || (o_ton_max_fault && !clear_req);
        case (state)
            STFR_ST_OFF: begin
                next_attempts = 3'h0; // RL16
                if (i_output_cmd_on && !i_other_fault_off) begin
                    next_state = STFR_ST_RAMP;
                end
            end
            STFR_ST_RAMP: begin
                if (i_vout_above_uv) begin
                    next_state = STFR_ST_RUN;
                end else if (fault_evt) begin
                    case (resp)
                        STFR_RESP_IGNORE: next_state = STFR_ST_RUN; // RL3
                        STFR_RESP_OPERATE: next_state = STFR_ST_OPERATE; // RL4
                        STFR_RESP_DISABLE: begin
                            next_state = can_retry ? STFR_ST_WAIT : STFR_ST_LATCHED; // RL5
                        end
                        default: next_state = STFR_ST_LATCHED; // RL6
                    endcase
                end
            end
            STFR_ST_RUN: begin
                next_state = STFR_ST_RUN;
            end
            STFR_ST_OPERATE: begin
                if (delay_done) begin
                    if (i_vout_above_uv) begin
                        next_state = STFR_ST_RUN;
                    end else begin
                        next_state = can_retry ? STFR_ST_WAIT : STFR_ST_LATCHED; // RL4
                    end
                end
            end
            STFR_ST_WAIT: begin
                if (delay_done) begin
                    next_state = STFR_ST_RAMP; // RL9
                    if (attempts != 3'h7) begin
                        next_attempts = attempts + 3'h1;
                    end
                end
            end
            STFR_ST_LATCHED: begin
                if (clear_req) begin
                    next_state = STFR_ST_OFF; // RL6
                end
            end
            default: next_state = STFR_ST_OFF;
        endcase
        // Off command or another shutdown fault ends every sequence.
        if (!i_output_cmd_on || i_other_fault_off) begin
            next_state = STFR_ST_OFF; // RL6 RL10 RL16
            next_attempts = 3'h0;
        end
    end

    // Restart the timer on every state change so each wait starts at zero.
    assign tmr_bus.clear = (next_state != state);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state <= STFR_ST_OFF;
            attempts <= 3'h0;
            o_ton_max_fault <= 1'b0;
            o_output_enable <= 1'b0;
            o_latched_off <= 1'b0;
            o_attempts <= 3'h0;
            o_state <= STFR_ST_OFF;
        end else begin
            state <= next_state;
            attempts <= next_attempts;
            o_ton_max_fault <= next_fault;
            o_output_enable <= (next_state == STFR_ST_RAMP) || (next_state == STFR_ST_RUN)
                || (next_state == STFR_ST_OPERATE);
            o_latched_off <= (next_state == STFR_ST_LATCHED);
            o_attempts <= next_attempts;
            o_state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_action_write: assert property ( // RL1
        (i_wr_stb && hit) |=> (action == map_action($past(i_wr_data))))
        else $error("action setting not written");
    a_resp_ignore: assert property ( // RL3
        (fault_evt && resp == STFR_RESP_IGNORE) |=> o_output_enable)
        else $error("ignore response interrupted output");
    a_operate_on: assert property ( // RL4
        (fault_evt && resp == STFR_RESP_OPERATE) |=> o_output_enable && state == STFR_ST_OPERATE)
        else $error("operate response did not keep running");
    a_disable_now: assert property ( // RL5
        (fault_evt && resp == STFR_RESP_DISABLE) |=> !o_output_enable)
        else $error("disable response left output on");
    a_latch_hold: assert property ( // RL6
        (state == STFR_ST_LATCHED && !clear_req && i_output_cmd_on) |=> !o_output_enable)
        else $error("latched output came back on");
    a_no_retry: assert property ( // RL7
        (fault_evt && resp == STFR_RESP_DISABLE && retries == 3'h0) |=> o_latched_off)
        else $error("zero retries did not latch");
    a_retry_budget: assert property ( // RL8
        (retries != 3'h7 && state == STFR_ST_WAIT) |-> attempts < retries)
        else $error("retry budget exceeded");
    a_spacing_time: assert property ( // RL9
        (state == STFR_ST_WAIT && next_state == STFR_ST_RAMP) |-> tmr_bus.elapsed_ms >= delay_lim)
        else $error("restart before spacing elapsed");
    a_limit_zero: assert property ( // RL15
        (i_ton_max_limit_ms == 16'h0000 && !o_ton_max_fault) |=> !o_ton_max_fault)
        else $error("fault with check disabled");
    a_count_clear: assert property ( // RL16
        !i_output_cmd_on |=> o_attempts == 3'h0 && state == STFR_ST_OFF)
        else $error("attempts not cleared on off");

    c_retry_restart: cover property (state == STFR_ST_WAIT ##1 state == STFR_ST_RAMP);
    c_latched: cover property (fault_evt ##1 o_latched_off);
    c_operate_ok: cover property (state == STFR_ST_OPERATE ##1 state == STFR_ST_RUN);
    c_readback: cover property (i_rd_stb && hit ##1 o_rd_valid);
endmodule

// >>> sim/stfr_plant.sv
// Behavioural converter output stage that reaches regulation a set time after enable.
`timescale 1ns/100ps
module stfr_plant (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Converter side
    input wire logic i_enable,
    input wire logic [15:0] i_rise_cycles,
    output logic o_vout_ok
);
    logic [15:0] cnt;
    // A rise time of zero models an output that never reaches the threshold.
    always_ff @(posedge i_clock) begin
        if (i_rst || !i_enable) begin
            cnt <= 16'h0000;
            o_vout_ok <= 1'b0;
        end else begin
            cnt <= (cnt == 16'hFFFF) ? cnt : cnt + 16'h0001;
            o_vout_ok <= (i_rise_cycles != 16'h0000) && (cnt >= i_rise_cycles);
        end
    end
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the startup-timeout fault-response block.
`timescale 1ns/100ps
`include "stfr_regs.svh"
module tb_top;
    import stfr_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_cmd_code = 8'h00;
    logic i_wr_stb = 1'b0;
    logic [7:0] i_wr_data = 8'h00;
    logic i_rd_stb = 1'b0;
    logic i_clear_status_bit = 1'b0;
    logic i_clear_faults = 1'b0;
    logic i_output_cmd_on = 1'b0;
    logic i_other_fault_off = 1'b0;
    logic [15:0] i_ton_max_limit_ms = 16'h0002;
    logic [7:0] i_vout_fault_unit_ms = 8'h01;
    logic [15:0] rise = 16'h0000;
    logic vout_ok;
    logic [7:0] o_rd_data;
    logic o_rd_valid;
    logic o_output_enable;
    logic o_ton_max_fault;
    logic o_latched_off;
    logic [2:0] o_attempts;
    stfr_state_e o_state;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int n;

    // A short millisecond keeps every delay a few cycles long.
    stfr_top #(.MS_CYCLES(4)) DUT (.i_clock(i_clock), .i_rst(i_rst), .i_cmd_code(i_cmd_code),
        .i_wr_stb(i_wr_stb), .i_wr_data(i_wr_data), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .i_clear_status_bit(i_clear_status_bit),
        .i_clear_faults(i_clear_faults), .i_output_cmd_on(i_output_cmd_on),
        .i_other_fault_off(i_other_fault_off), .i_vout_above_uv(vout_ok),
        .i_ton_max_limit_ms(i_ton_max_limit_ms), .i_vout_fault_unit_ms(i_vout_fault_unit_ms),
        .o_output_enable(o_output_enable), .o_ton_max_fault(o_ton_max_fault),
        .o_latched_off(o_latched_off), .o_attempts(o_attempts), .o_state(o_state));
    stfr_plant u_plant (.i_clock(i_clock), .i_rst(i_rst), .i_enable(o_output_enable),
        .i_rise_cycles(rise), .o_vout_ok(vout_ok));

    initial begin
        forever #20 i_clock = ~i_clock;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        if (err_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("FAIL %s expected %0d to %0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        @(posedge i_clock);
        i_cmd_code <= cmd;
        i_wr_data <= d;
        i_wr_stb <= 1'b1;
        @(posedge i_clock);
        i_wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input logic vld);
        @(posedge i_clock);
        i_cmd_code <= cmd;
        i_rd_stb <= 1'b1;
        @(posedge i_clock);
        i_rd_stb <= 1'b0;
        #1;
        chk("read valid", {7'h00, vld}, {7'h00, o_rd_valid});
        chk("read data", exp, o_rd_data);
    endtask
    task automatic wait_st(input stfr_state_e s);
        n = 0;
        #1;
        while (o_state !== s && n < 3000) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        chk("state", {5'h00, s}, {5'h00, o_state});
    endtask
    task automatic wait_flt;
        n = 0;
        #1;
        while (o_ton_max_fault !== 1'b1 && n < 3000) begin
            @(posedge i_clock);
            #1;
            n++;
        end
    endtask
    task automatic measure(input logic lvl);
        n = 0;
        #1;
        while (o_output_enable === lvl && n < 3000) begin
            @(posedge i_clock);
            #1;
            n++;
        end
    endtask
    task automatic start(input logic [7:0] cfg, input logic [15:0] r);
        @(posedge i_clock);
        i_output_cmd_on <= 1'b0;
        i_clear_status_bit <= 1'b1;
        @(posedge i_clock);
        i_clear_status_bit <= 1'b0;
        wr(`STFR_CMD_ACTION, cfg);
        rise <= r;
        @(posedge i_clock);
        i_output_cmd_on <= 1'b1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reg;
        rd(`STFR_CMD_ACTION, `STFR_ACTION_RST, 1'b1);
        wr(`STFR_CMD_ACTION, 8'h8A);
        rd(`STFR_CMD_ACTION, 8'h8A, 1'b1);
        wr(8'h62, 8'h55);
        rd(8'h62, 8'h8A, 1'b0);
        rd(`STFR_CMD_ACTION, 8'h8A, 1'b1);
    endtask
    task automatic t_ok;
        start(8'hC0, 16'h0003);
        wait_st(STFR_ST_RUN);
        repeat (40) @(posedge i_clock);
        #1;
        chk("fault after good start", 8'h00, {7'h00, o_ton_max_fault});
    endtask
    task automatic t_ignore;
        start(8'h00, 16'h0000);
        wait_flt;
        chk_rng("fault time", 8, 12, n);
        repeat (40) @(posedge i_clock);
        #1;
        chk("enable when ignored", 8'h01, {7'h00, o_output_enable});
    endtask
    task automatic t_retry;
        start(8'h89, 16'h0000);
        wait_flt;
        chk("enable at fault", 8'h00, {7'h00, o_output_enable});
        measure(1'b0);
        chk_rng("retry spacing", 7, 10, n);
        chk("attempts", 8'h01, {5'h00, o_attempts});
        wait_st(STFR_ST_LATCHED);
        repeat (20) @(posedge i_clock);
        #1;
        chk("latched", 8'h01, {7'h00, o_latched_off});
        chk("enable latched", 8'h00, {7'h00, o_output_enable});
        @(posedge i_clock) i_clear_faults <= 1'b1;
        @(posedge i_clock);
        i_clear_faults <= 1'b0;
        wait_st(STFR_ST_RAMP);
        chk("attempts cleared", 8'h00, {5'h00, o_attempts});
    endtask
    task automatic t_operate;
        @(posedge i_clock) i_vout_fault_unit_ms <= 8'h02;
        start(8'h40, 16'h0000);
        wait_flt;
        measure(1'b1);
        chk_rng("operate delay", 7, 10, n);
        wait_st(STFR_ST_LATCHED);
        @(posedge i_clock) i_vout_fault_unit_ms <= 8'h01;
    endtask
    task automatic t_latch;
        start(8'hC0, 16'h0000);
        wait_st(STFR_ST_LATCHED);
        repeat (40) @(posedge i_clock);
        #1;
        chk("enable held off", 8'h00, {7'h00, o_output_enable});
        @(posedge i_clock) i_output_cmd_on <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_output_cmd_on <= 1'b1;
        wait_st(STFR_ST_RAMP);
    endtask
    task automatic t_forever;
        start(8'hB8, 16'h0000);
        repeat (400) @(posedge i_clock);
        #1;
        chk("not latched", 8'h00, {7'h00, o_latched_off});
        chk("attempts saturate", 8'h07, {5'h00, o_attempts});
        @(posedge i_clock) i_other_fault_off <= 1'b1;
        wait_st(STFR_ST_OFF);
        chk("attempts reset", 8'h00, {5'h00, o_attempts});
        @(posedge i_clock) i_other_fault_off <= 1'b0;
    endtask
    task automatic t_nolimit;
        @(posedge i_clock) i_ton_max_limit_ms <= 16'h0000;
        start(8'hC0, 16'h0000);
        repeat (100) @(posedge i_clock);
        #1;
        chk("fault without limit", 8'h00, {7'h00, o_ton_max_fault});
        chk("still ramping", {5'h00, STFR_ST_RAMP}, {5'h00, o_state});
        @(posedge i_clock) i_ton_max_limit_ms <= 16'h0002;
    endtask

    // ------------------------------------------------------------
    // Sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reg();
        t_ok();
        t_ignore();
        t_retry();
        t_operate();
        t_latch();
        t_forever();
        t_nolimit();
        give_verdict();
    end
endmodule
